// ===== rtl/rgfc_regs.sv
// receiver gain, filter and post-demod config register bank on APB
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module rgfc_regs #(
	parameter int ADDR_W = 8
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic [3:0] GAIN_RELEASE_THRESHOLD,
	output rgfc_pkg::rgfc_gain_mode_t GAIN_CONTROL_MODE,
	output logic GAIN_CTRL_EN,
	output logic GAIN_MAX,
	output logic ADC_BUF_BACKOFF,
	output logic MOD_FSK,
	output logic IF_200K,
	output logic [2:0] CHANNEL_FILTER_SELECT,
	output logic CHAN_FILT_VALID,
	output logic [8:0] RX_BW_WIDE_KHZ,
	output logic [8:0] RX_BW_NARROW_KHZ,
	output logic LOW_DELAY_BUF,
	output logic LOW_DELAY_ILLEGAL,
	output logic POST_BW_BOOST,
	output logic signed [3:0] RATE_SHIFT,
	output logic [3:0] RATE_DENOM
);
	import rgfc_pkg::*;
	`include "rgfc_cfg.svh"

	rgfc_byte_t gain_cfg;
	rgfc_byte_t filt_sel;
	rgfc_byte_t post_demod_filter_config;
	rgfc_byte_t status;
	rgfc_gain_mode_t mode_f;
	logic d_gain_on;
	logic d_max_gain;
	logic d_backoff;
	logic d_chf_valid;
	logic [8:0] d_bw_wide;
	logic [8:0] d_bw_narrow;
	logic signed [3:0] d_rate_shift;
	logic [3:0] d_rate_denom;
	logic d_ld_legal;
	logic ld_bad;

	rgfc_bus_if bus ();

	rgfc_apb_slave #(
		.ADDR_W(ADDR_W)
	) u_apb (
		.clk(CLK),
		.rst(SYS_RST),
		.psel(PSEL),
		.penable(PENABLE),
		.pwrite(PWRITE),
		.paddr(PADDR),
		.pwdata(PWDATA),
		.prdata(PRDATA),
		.pready(PREADY),
		.pslverr(PSLVERR),
		.bus(bus.slave)
	);

	// mapped indices; status answers reads and ignores writes
	always_comb begin
		bus.hit = 1'b1;
		bus.rdata = 8'h00;
		case (bus.idx)
			`RGFC_IDX_GAIN: bus.rdata = gain_cfg;
			`RGFC_IDX_FILT: bus.rdata = filt_sel;
			`RGFC_IDX_PDF: bus.rdata = post_demod_filter_config;
			`RGFC_IDX_STAT: bus.rdata = status;
			default: bus.hit = 1'b0;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			gain_cfg <= `RGFC_GAIN_RST;
		end else if (bus.wr && bus.idx == `RGFC_IDX_GAIN) begin
			gain_cfg <= bus.wdata & `RGFC_GAIN_MASK;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			filt_sel <= `RGFC_FILT_RST;
		end else if (bus.wr && bus.idx == `RGFC_IDX_FILT) begin
			filt_sel <= bus.wdata & `RGFC_FILT_MASK;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			post_demod_filter_config <= `RGFC_PDF_RST;
		end else if (bus.wr && bus.idx == `RGFC_IDX_PDF) begin
			post_demod_filter_config <= bus.wdata;
		end
	end

	assign mode_f = rgfc_gain_mode_t'(gain_cfg[`RGFC_MODE_HI:`RGFC_MODE_LO]);

	rgfc_decode u_dec (
		.mode(mode_f),
		.chf(filt_sel[`RGFC_CHF_HI:`RGFC_CHF_LO]),
		.lg(post_demod_filter_config[`RGFC_LG_HI:`RGFC_LG_LO]),
		.sm(post_demod_filter_config[`RGFC_SM_HI:`RGFC_SM_LO]),
		.gain_on(d_gain_on),
		.max_gain(d_max_gain),
		.backoff(d_backoff),
		.chf_valid(d_chf_valid),
		.bw_wide(d_bw_wide),
		.bw_narrow(d_bw_narrow),
		.rate_shift(d_rate_shift),
		.rate_denom(d_rate_denom),
		.ld_legal(d_ld_legal)
	);

	// flag a low-delay pick the rate setting forbids
	assign ld_bad = post_demod_filter_config[`RGFC_LDBUF_BIT] && !d_ld_legal;

	// status is a live view, nothing to clear
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			status <= 8'h00;
		end else begin
			status <= 8'h00;
			status[`RGFC_STAT_CHF_BAD] <= !d_chf_valid;
			status[`RGFC_STAT_LD_BAD] <= ld_bad;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			GAIN_RELEASE_THRESHOLD <= 4'h0;
			GAIN_CONTROL_MODE <= RGFC_GC_OFF_MAX;
			GAIN_CTRL_EN <= 1'b0;
			GAIN_MAX <= 1'b0;
			ADC_BUF_BACKOFF <= 1'b0;
		end else begin
			GAIN_RELEASE_THRESHOLD <= gain_cfg[`RGFC_THREL_HI:`RGFC_THREL_LO];
			GAIN_CONTROL_MODE <= mode_f;
			GAIN_CTRL_EN <= d_gain_on;
			GAIN_MAX <= d_max_gain;
			ADC_BUF_BACKOFF <= d_backoff;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			MOD_FSK <= 1'b0;
			IF_200K <= 1'b0;
			CHANNEL_FILTER_SELECT <= 3'h0;
			CHAN_FILT_VALID <= 1'b0;
			RX_BW_WIDE_KHZ <= 9'h000;
			RX_BW_NARROW_KHZ <= 9'h000;
		end else begin
			MOD_FSK <= filt_sel[`RGFC_FSK_BIT];
			IF_200K <= filt_sel[`RGFC_IF_BIT];
			CHANNEL_FILTER_SELECT <= filt_sel[`RGFC_CHF_HI:`RGFC_CHF_LO];
			CHAN_FILT_VALID <= d_chf_valid;
			RX_BW_WIDE_KHZ <= d_bw_wide;
			RX_BW_NARROW_KHZ <= d_bw_narrow;
		end
	end

	// boost and rate controls; illegal buffer choice is passed on, only flagged
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			LOW_DELAY_BUF <= 1'b0;
			LOW_DELAY_ILLEGAL <= 1'b0;
			POST_BW_BOOST <= 1'b0;
			RATE_SHIFT <= 4'sh0;
			RATE_DENOM <= `RGFC_SM_BASE;
		end else begin
			LOW_DELAY_BUF <= post_demod_filter_config[`RGFC_LDBUF_BIT];
			LOW_DELAY_ILLEGAL <= ld_bad;
			POST_BW_BOOST <= post_demod_filter_config[`RGFC_LDBW_BIT];
			RATE_SHIFT <= d_rate_shift;
			RATE_DENOM <= d_rate_denom;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	sequence s_wr_gain;
		bus.wr && bus.idx == `RGFC_IDX_GAIN;
	endsequence
	sequence s_wr_filt;
		bus.wr && bus.idx == `RGFC_IDX_FILT;
	endsequence
	sequence s_wr_pdf;
		bus.wr && bus.idx == `RGFC_IDX_PDF;
	endsequence
	sequence s_wr_unmapped;
		PSEL && PENABLE && PREADY && PWRITE && !bus.hit;
	endsequence
	sequence s_wr_status;
		PSEL && PENABLE && PREADY && PWRITE && bus.idx == `RGFC_IDX_STAT;
	endsequence

	AST_THREL_FOLLOWS_WRITE: assert property (
		s_wr_gain |-> ##2 GAIN_RELEASE_THRESHOLD == $past(bus.wdata[5:2], 2))
		else $error("release threshold does not follow its write");
	AST_MODE_MAX_GAIN: assert property (
		s_wr_gain ##0 bus.wdata[1:0] == 2'h0 |-> ##2 GAIN_MAX && !GAIN_CTRL_EN && !ADC_BUF_BACKOFF)
		else $error("mode 0 does not give fixed maximum gain");
	AST_MODE_ON_BACKOFF: assert property (
		s_wr_gain ##0 bus.wdata[1:0] == 2'h3 |-> ##2 GAIN_CTRL_EN && ADC_BUF_BACKOFF && !GAIN_MAX)
		else $error("mode 3 does not enable control with backoff");
	AST_CHF_WIDEST: assert property (
		s_wr_filt ##0 bus.wdata[2:0] == 3'h0 |-> ##2 RX_BW_WIDE_KHZ == 9'h154 && RX_BW_NARROW_KHZ == 9'h0AA)
		else $error("filter code 0 does not give the widest pair");
	AST_CHF_INVALID: assert property (
		CHANNEL_FILTER_SELECT > 3'h4 |-> !CHAN_FILT_VALID && RX_BW_WIDE_KHZ == 9'h000)
		else $error("invalid filter code reported valid");
	AST_LDBUF_FOLLOWS_WRITE: assert property (
		s_wr_pdf |-> ##2 LOW_DELAY_BUF == $past(bus.wdata[7], 2))
		else $error("low-delay buffer select does not follow its write");
	AST_LD_ILLEGAL_FLAG: assert property (
		s_wr_pdf ##0 bus.wdata[7] && bus.wdata[5:3] == 3'h2 && bus.wdata[0] |-> ##2 LOW_DELAY_ILLEGAL)
		else $error("forbidden low-delay choice not flagged");
	AST_BW_BOOST: assert property (
		s_wr_pdf |-> ##2 POST_BW_BOOST == $past(bus.wdata[6], 2))
		else $error("bandwidth boost does not follow its write");
	AST_MOD_IF_SELECT: assert property (
		s_wr_filt |-> ##2 MOD_FSK == $past(bus.wdata[4], 2) && IF_200K == $past(bus.wdata[3], 2))
		else $error("modulation or IF select does not follow its write");
	AST_RATE_LARGE: assert property (
		s_wr_pdf ##0 bus.wdata[5:3] == 3'h7 |-> ##2 RATE_SHIFT == -4'sd5)
		else $error("large adjust 7 does not give one thirty-second");
	AST_RATE_SMALL: assert property (
		s_wr_pdf |-> ##2 RATE_DENOM == 4'h8 + {1'b0, $past(bus.wdata[2:0], 2)})
		else $error("small adjust divisor wrong");

	// reserved bits never store anything
	AST_GAIN_RESERVED_ZERO: assert property (
		gain_cfg[7:6] == 2'h0)
		else $error("reserved gain bits hold a one");
	AST_FILT_RESERVED_ZERO: assert property (
		filt_sel[7:5] == 3'h0)
		else $error("reserved filter bits hold a one");

	// a refused or read-only write must leave every register alone
	AST_UNMAPPED_WRITE_IGNORED: assert property (
		s_wr_unmapped |=> $stable(gain_cfg) && $stable(filt_sel) && $stable(post_demod_filter_config))
		else $error("unmapped write changed a register");
	AST_STATUS_WRITE_IGNORED: assert property (
		s_wr_status |=> $stable(gain_cfg) && $stable(filt_sel) && $stable(post_demod_filter_config))
		else $error("status write changed a register");

	AST_MODE_FOLLOWS_WRITE: assert property (
		s_wr_gain |-> ##2 GAIN_CONTROL_MODE == $past(bus.wdata[1:0], 2))
		else $error("mode pins do not follow their write");
	AST_MODE_OFF_BACKOFF: assert property (
		s_wr_gain ##0 bus.wdata[1:0] == 2'h1 |-> ##2 !GAIN_CTRL_EN && !GAIN_MAX && ADC_BUF_BACKOFF)
		else $error("mode 1 does not give fixed gain with backoff");
	AST_MODE_ON: assert property (
		s_wr_gain ##0 bus.wdata[1:0] == 2'h2 |-> ##2 GAIN_CTRL_EN && !GAIN_MAX && !ADC_BUF_BACKOFF)
		else $error("mode 2 does not enable control alone");

	AST_CHF_FOLLOWS_WRITE: assert property (
		s_wr_filt |-> ##2 CHANNEL_FILTER_SELECT == $past(bus.wdata[2:0], 2))
		else $error("filter select pins do not follow their write");
	AST_CHF_SECOND: assert property (
		s_wr_filt ##0 bus.wdata[2:0] == 3'h1 |->
			##2 RX_BW_WIDE_KHZ == 9'h078 && RX_BW_NARROW_KHZ == 9'h03C)
		else $error("filter code 1 does not give its pair");
	AST_CHF_NARROWEST: assert property (
		s_wr_filt ##0 bus.wdata[2:0] == 3'h4 |->
			##2 RX_BW_WIDE_KHZ == 9'h00C && RX_BW_NARROW_KHZ == 9'h006)
		else $error("filter code 4 does not give the narrowest pair");
	AST_STATUS_CHF_LIVE: assert property (
		s_wr_filt |-> ##2 status[`RGFC_STAT_CHF_BAD] == !CHAN_FILT_VALID)
		else $error("status filter bit disagrees with the valid pin");

	AST_LD_LEGAL_NO_FLAG: assert property (
		s_wr_pdf ##0 bus.wdata[5:3] >= 3'h3 |-> ##2 !LOW_DELAY_ILLEGAL)
		else $error("permitted low-delay choice flagged");
	AST_LD_FLAG_NEEDS_BUF: assert property (
		LOW_DELAY_ILLEGAL |-> LOW_DELAY_BUF)
		else $error("illegal flag raised without the low-delay buffer");
	AST_STATUS_LD_LIVE: assert property (
		s_wr_pdf |-> ##2 status[`RGFC_STAT_LD_BAD] == LOW_DELAY_ILLEGAL)
		else $error("status buffer bit disagrees with the illegal pin");

	AST_RATE_DEFAULT: assert property (
		s_wr_pdf ##0 bus.wdata[5:3] == 3'h2 |-> ##2 RATE_SHIFT == 4'sd0)
		else $error("large adjust 2 does not keep the default rate");
	AST_RATE_FASTEST: assert property (
		s_wr_pdf ##0 bus.wdata[5:3] == 3'h0 |-> ##2 RATE_SHIFT == 4'sd2)
		else $error("large adjust 0 does not give four times the rate");
endmodule
`default_nettype wire

// ===== shared/rgfc_cfg.svh
// register map, field positions, reset values and decode figures of the receiver config bank
// How it works
// - release threshold fine-tune is a 4-bit read/write field, bits 5:2
// - mode field: off max gain, off backoff, on, on with backoff
// - channel filter codes 0..4 give bandwidth pairs; 5..7 are invalid
// - bit 7 of post filter config picks the low-delay output buffer
// - large rate adjust: code 0 is 4x, 2 default, 7 is 1/32
// - small rate adjust code n scales rate by 8/(8+n)
`ifndef RGFC_CFG_SVH
`define RGFC_CFG_SVH
`define RGFC_IDX_GAIN 6'h01
`define RGFC_IDX_FILT 6'h02
`define RGFC_IDX_PDF 6'h03
`define RGFC_IDX_STAT 6'h05
`define RGFC_ADDR_LSB 2
`define RGFC_GAIN_RST 8'h02
`define RGFC_FILT_RST 8'h00
`define RGFC_PDF_RST 8'h10
`define RGFC_GAIN_MASK 8'h3F
`define RGFC_FILT_MASK 8'h1F
`define RGFC_THREL_HI 5
`define RGFC_THREL_LO 2
`define RGFC_MODE_HI 1
`define RGFC_MODE_LO 0
`define RGFC_FSK_BIT 4
`define RGFC_IF_BIT 3
`define RGFC_CHF_HI 2
`define RGFC_CHF_LO 0
`define RGFC_LDBUF_BIT 7
`define RGFC_LDBW_BIT 6
`define RGFC_LG_HI 5
`define RGFC_LG_LO 3
`define RGFC_SM_HI 2
`define RGFC_SM_LO 0
`define RGFC_STAT_CHF_BAD 0
`define RGFC_STAT_LD_BAD 1
`define RGFC_CHF_LAST 3'h4
`define RGFC_LG_DEFAULT 3'h2
`define RGFC_LG_LD_MIN 3'h3
`define RGFC_SM_BASE 4'h8
`define RGFC_BW0_KHZ 9'h154
`define RGFC_BW1_KHZ 9'h078
`define RGFC_BW2_KHZ 9'h034
`define RGFC_BW3_KHZ 9'h018
`define RGFC_BW4_KHZ 9'h00C
`endif

// ===== shared/rgfc_pkg.sv
// types shared by the receiver config bank modules
package rgfc_pkg;
	typedef enum logic [1:0] {
		RGFC_GC_OFF_MAX = 2'b00,
		RGFC_GC_OFF_BO = 2'b01,
		RGFC_GC_ON = 2'b10,
		RGFC_GC_ON_BO = 2'b11
	} rgfc_gain_mode_t;
	typedef logic [7:0] rgfc_byte_t;
	typedef logic [5:0] rgfc_idx_t;
endpackage

// ===== shared/rgfc_bus_if.sv
// internal register access carrier between bus slave and register bank
`timescale 1ns/1ps
`default_nettype none
interface rgfc_bus_if;
	logic wr;
	rgfc_pkg::rgfc_idx_t idx;
	rgfc_pkg::rgfc_byte_t wdata;
	rgfc_pkg::rgfc_byte_t rdata;
	logic hit;
	modport slave (output wr, output idx, output wdata, input rdata, input hit);
	modport bank (input wr, input idx, input wdata, output rdata, output hit);
endinterface
`default_nettype wire

// ===== rtl/rgfc_apb_slave.sv
// APB slave front end with one wait state and registered read data
`timescale 1ns/1ps
`default_nettype none
module rgfc_apb_slave #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	rgfc_bus_if.slave bus
);
	import rgfc_pkg::*;
	`include "rgfc_cfg.svh"

	logic access;
	logic ready_q;
	logic err_q;
	rgfc_byte_t rdata_q;

	assign access = psel && penable;
	assign pready = ready_q;
	assign pslverr = ready_q && err_q;
	assign prdata = {24'h000000, rdata_q};
	// write lands only on the completing edge
	assign bus.wr = access && ready_q && pwrite && bus.hit;
	assign bus.idx = rgfc_idx_t'(paddr[ADDR_W-1:`RGFC_ADDR_LSB]);
	assign bus.wdata = pwdata[7:0];

	// one wait state lets read data come from a flop
	always_ff @(posedge clk) begin
		if (rst) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= access && !ready_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= 8'h00;
			err_q <= 1'b0;
		end else if (access && !ready_q) begin
			rdata_q <= pwrite ? 8'h00 : bus.rdata;
			err_q <= !bus.hit;
		end
	end

	AST_READY_NEXT: assert property (@(posedge clk) disable iff (rst)
		access && !ready_q |=> pready)
		else $error("access phase not completed after one wait state");
	AST_READY_ONLY_ACCESS: assert property (@(posedge clk) disable iff (rst)
		pready |-> $past(access))
		else $error("ready raised outside an access phase");
endmodule
`default_nettype wire

// ===== rtl/rgfc_decode.sv
// combinational decode of the configuration fields into block controls
`timescale 1ns/1ps
`default_nettype none
module rgfc_decode (
	input wire rgfc_pkg::rgfc_gain_mode_t mode,
	input wire logic [2:0] chf,
	input wire logic [2:0] lg,
	input wire logic [2:0] sm,
	output logic gain_on,
	output logic max_gain,
	output logic backoff,
	output logic chf_valid,
	output logic [8:0] bw_wide,
	output logic [8:0] bw_narrow,
	output logic signed [3:0] rate_shift,
	output logic [3:0] rate_denom,
	output logic ld_legal
);
	import rgfc_pkg::*;
	`include "rgfc_cfg.svh"

	function automatic logic [8:0] bw_khz(input logic [2:0] code);
		case (code)
			3'h0: bw_khz = `RGFC_BW0_KHZ;
			3'h1: bw_khz = `RGFC_BW1_KHZ;
			3'h2: bw_khz = `RGFC_BW2_KHZ;
			3'h3: bw_khz = `RGFC_BW3_KHZ;
			3'h4: bw_khz = `RGFC_BW4_KHZ;
			default: bw_khz = 9'h000;
		endcase
	endfunction

	always_comb begin
		unique case (mode)
			RGFC_GC_OFF_MAX: begin
				gain_on = 1'b0;
				max_gain = 1'b1;
				backoff = 1'b0;
			end
			RGFC_GC_OFF_BO: begin
				gain_on = 1'b0;
				max_gain = 1'b0;
				backoff = 1'b1;
			end
			RGFC_GC_ON: begin
				gain_on = 1'b1;
				max_gain = 1'b0;
				backoff = 1'b0;
			end
			RGFC_GC_ON_BO: begin
				gain_on = 1'b1;
				max_gain = 1'b0;
				backoff = 1'b1;
			end
		endcase
	end

	assign chf_valid = chf <= `RGFC_CHF_LAST;
	assign bw_wide = bw_khz(chf);
	assign bw_narrow = bw_khz(chf) >> 1;
	assign rate_shift = 4'(signed'({1'b0, `RGFC_LG_DEFAULT}) - signed'({1'b0, lg}));
	assign rate_denom = `RGFC_SM_BASE + {1'b0, sm};
	assign ld_legal = (lg >= `RGFC_LG_LD_MIN) || (lg == `RGFC_LG_DEFAULT && !sm[0]);
endmodule
`default_nettype wire

// ===== bench/rgfc_regs_tb.sv
// self-checking bench for the receiver config register bank
`timescale 1ns/1ps
`default_nettype none
`include "rgfc_cfg.svh"
module rgfc_regs_tb;
	import rgfc_pkg::*;
	localparam logic [7:0] A_GAIN = {`RGFC_IDX_GAIN, 2'b00};
	localparam logic [7:0] A_FILT = {`RGFC_IDX_FILT, 2'b00};
	localparam logic [7:0] A_PDF = {`RGFC_IDX_PDF, 2'b00};
	localparam logic [7:0] A_STAT = {`RGFC_IDX_STAT, 2'b00};
	logic CLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic [3:0] GAIN_RELEASE_THRESHOLD, RATE_DENOM;
	rgfc_gain_mode_t GAIN_CONTROL_MODE;
	logic GAIN_CTRL_EN, GAIN_MAX, ADC_BUF_BACKOFF, MOD_FSK, IF_200K, CHAN_FILT_VALID;
	logic [2:0] CHANNEL_FILTER_SELECT;
	logic [8:0] RX_BW_WIDE_KHZ, RX_BW_NARROW_KHZ;
	logic LOW_DELAY_BUF, LOW_DELAY_ILLEGAL, POST_BW_BOOST;
	logic signed [3:0] RATE_SHIFT;
	int n_mismatch = 0;
	int total_checks = 0;
	rgfc_regs #(.ADDR_W(8)) rgfc_regs_inst (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .GAIN_RELEASE_THRESHOLD(GAIN_RELEASE_THRESHOLD),
		.GAIN_CONTROL_MODE(GAIN_CONTROL_MODE), .GAIN_CTRL_EN(GAIN_CTRL_EN), .GAIN_MAX(GAIN_MAX),
		.ADC_BUF_BACKOFF(ADC_BUF_BACKOFF), .MOD_FSK(MOD_FSK), .IF_200K(IF_200K),
		.CHANNEL_FILTER_SELECT(CHANNEL_FILTER_SELECT), .CHAN_FILT_VALID(CHAN_FILT_VALID),
		.RX_BW_WIDE_KHZ(RX_BW_WIDE_KHZ), .RX_BW_NARROW_KHZ(RX_BW_NARROW_KHZ),
		.LOW_DELAY_BUF(LOW_DELAY_BUF), .LOW_DELAY_ILLEGAL(LOW_DELAY_ILLEGAL),
		.POST_BW_BOOST(POST_BW_BOOST), .RATE_SHIFT(RATE_SHIFT), .RATE_DENOM(RATE_DENOM));
	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask
	// one transfer; pready and the answer are read at the rising edge, as the slave saw them
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_mismatch++;
			$display("BAD %0t no pready", $time);
		end
		rd = PRDATA;
		er = PSLVERR;
		// released only after the completing edge
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, a, {24'h0, d}, rd, er);
		chk(er, 1'b0, "write error");
		// decoded pins lag the register by one edge
		repeat (2) @(negedge CLK);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic eer);
		logic [31:0] rd;
		logic er;
		apb(1'b0, a, 32'h0, rd, er);
		chk(rd, exp, "read data");
		chk(er, eer, "read error");
	endtask
	function automatic logic [8:0] bw(input logic [2:0] c);
		case (c)
			3'h0: return 9'h154;
			3'h1: return 9'h078;
			3'h2: return 9'h034;
			3'h3: return 9'h018;
			3'h4: return 9'h00C;
			default: return 9'h000;
		endcase
	endfunction
	task automatic t_reset();
		rdchk(A_GAIN, 32'h02, 1'b0);
		rdchk(A_FILT, 32'h00, 1'b0);
		rdchk(A_PDF, 32'h10, 1'b0);
		chk({GAIN_CTRL_EN, GAIN_MAX, ADC_BUF_BACKOFF}, 3'h4, "reset mode");
		chk({$unsigned(RATE_SHIFT), RATE_DENOM}, 8'h08, "reset rate");
		chk(RX_BW_WIDE_KHZ, 9'h154, "reset bw");
		$display("done reset");
	endtask
	task automatic t_gain();
		logic [1:0] m;
		wr(A_GAIN, 8'hFF);
		rdchk(A_GAIN, 32'h3F, 1'b0);
		chk(GAIN_RELEASE_THRESHOLD, 4'hF, "threshold");
		for (int i = 0; i < 4; i++) begin
			m = i[1:0];
			// fine-tune as software sets it for slow data
			wr(A_GAIN, {2'h0, 4'h9, m});
			chk(GAIN_CONTROL_MODE, m, "mode");
			chk({GAIN_CTRL_EN, GAIN_MAX, ADC_BUF_BACKOFF}, {m[1], m == 2'h0, m[0]}, "dec");
			chk(GAIN_RELEASE_THRESHOLD, 4'h9, "threshold");
		end
		$display("done gain");
	endtask
	task automatic t_filter();
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			wr(A_FILT, {3'h0, c[0], c[1], c});
			chk(CHANNEL_FILTER_SELECT, c, "chf");
			chk(CHAN_FILT_VALID, c <= 3'h4, "chf valid");
			chk(RX_BW_WIDE_KHZ, bw(c), "bw wide");
			chk(RX_BW_NARROW_KHZ, bw(c) >> 1, "bw narrow");
			chk({MOD_FSK, IF_200K}, {c[0], c[1]}, "fsk if");
			rdchk(A_STAT, {31'h0, c > 3'h4}, 1'b0);
		end
		wr(A_FILT, 8'h00);
		$display("done filter");
	endtask
	task automatic t_pdf();
		logic [2:0] lg, sm;
		logic bad;
		for (int i = 0; i < 64; i++) begin
			lg = i[5:3];
			sm = i[2:0];
			bad = !(lg >= 3'h3 || (lg == 3'h2 && !sm[0]));
			wr(A_PDF, {1'b1, sm[0], lg, sm});
			chk(LOW_DELAY_BUF, 1'b1, "low_delay_buffer_select");
			chk(POST_BW_BOOST, sm[0], "bw boost");
			chk($unsigned(RATE_SHIFT), 4'(4'h2 - {1'b0, lg}), "shift");
			chk(RATE_DENOM, 4'h8 + {1'b0, sm}, "denom");
			chk(LOW_DELAY_ILLEGAL, bad, "ld illegal");
		end
		// large adjust 2 with odd small adjust forbids the low-delay buffer
		wr(A_PDF, 8'h91);
		chk(LOW_DELAY_ILLEGAL, 1'b1, "ld illegal odd");
		rdchk(A_PDF, 32'h91, 1'b0);
		rdchk(A_STAT, 32'h2, 1'b0);
		wr(A_PDF, 8'h10);
		chk({LOW_DELAY_BUF, LOW_DELAY_ILLEGAL}, 2'h0, "ld off");
		$display("done pdf");
	endtask
	task automatic t_errors();
		logic [31:0] rd;
		logic er;
		apb(1'b1, 8'h3C, 32'hFF, rd, er);
		chk(er, 1'b1, "unmapped write");
		rdchk(8'h3C, 32'h0, 1'b1);
		// status is read-only: write accepted silently, contents unchanged
		apb(1'b1, A_STAT, 32'hFF, rd, er);
		chk(er, 1'b0, "status write");
		rdchk(A_STAT, 32'h0, 1'b0);
		rdchk(A_GAIN, 32'h27, 1'b0);
		$display("done errors");
	endtask
	task automatic t_rerst();
		wr(A_PDF, 8'hD1);
		chk({LOW_DELAY_ILLEGAL, POST_BW_BOOST}, 2'h3, "before reset");
		@(posedge CLK);
		SYS_RST <= 1'b1;
		repeat (3) @(posedge CLK);
		SYS_RST <= 1'b0;
		repeat (2) @(negedge CLK);
		chk({LOW_DELAY_BUF, LOW_DELAY_ILLEGAL, POST_BW_BOOST}, 3'h0, "reset ld");
		chk(RATE_DENOM, 4'h8, "reset denom");
		rdchk(A_PDF, 32'h10, 1'b0);
		rdchk(A_GAIN, 32'h02, 1'b0);
		$display("done rerst");
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		#400000;
		n_mismatch++;
		$display("BAD %0t watchdog", $time);
		stop_test();
	end
	initial begin
		SYS_RST = 1'b1;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		repeat (10) @(posedge CLK);
		SYS_RST <= 1'b0;
		repeat (2) @(negedge CLK);
		t_reset();
		t_gain();
		t_filter();
		t_pdf();
		t_errors();
		t_rerst();
		stop_test();
	end
endmodule
`default_nettype wire
